// >>> include/gpio_pkg.sv
// Purpose: shared constants and types for the six-pin general purpose port
// Assumes: 32-bit register words at byte offsets, one system clock
// Notes: the global interrupt status offset is a local choice
package gpio_pkg;

  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_STATUS = 12'h0058;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_ENABLE = 12'h005C;
  localparam logic [ADDR_W-1:0] OFS_PIN_CONFIG = 12'h01E0;
  localparam logic [ADDR_W-1:0] OFS_DATA_DIR = 12'h01E4;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_INTERRUPT_STATUS_EN = 12'h01E8;

  // field positions
  localparam int unsigned LOW_FIELD_LSB = 0;
  localparam int unsigned HIGH_FIELD_LSB = 16;
  localparam int unsigned PIN_EVENT_BIT = 12;

  // reset values
  localparam logic [PIN_COUNT-1:0] PIN_FIELD_RST = 6'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // least active time of an interrupt level
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MIN_ACTIVE_NS = 40;
  localparam int unsigned MIN_ACTIVE_CYC =
    (MIN_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
  } reg_rsp_t;

endpackage : gpio_pkg

// >>> design/pin_sync.sv
// Purpose: two-stage synchroniser for the pin inputs
// Assumes: pins are asynchronous to i_sys_clk
// Notes: the first stage feeds only the second stage
module pin_sync #(
  parameter int unsigned WIDTH = 6
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // idle pins are pulled up; resetting low would fake an active
      // low-level interrupt right after reset
      stage1 <= '1;
      o_sync <= '1;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule // pin_sync

// >>> design/gpio_port.sv
// Purpose: six-pin general purpose port with level interrupts
// Assumes: register port requests are synchronous to i_sys_clk
// Notes: read data and ack come one cycle after the request
//
// What this block does
// - direction bit set means output, reset input
// - output pins drive last written data bit
// - input pins read back sampled pin level
// - output pins read back the data latch
// - write one clears status, zero keeps
// - per-pin enables gate status as sources
// - status sets regardless of per-pin enable
// - enabled status ORed into global event bit
// - irq needs global pin enable too
// - level sensitive, held over 40 ns
// - polarity bit picks low or high trigger
// - buffer bit clear gives open drain
// - event bit twelve, read only
module gpio_port
  import gpio_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // register port
  input wire reg_req_t i_req,
  output reg_rsp_t o_rsp,
  // pins
  input wire logic [PINS-1:0] i_pin,
  output logic [PINS-1:0] o_pin_out,
  output logic [PINS-1:0] o_pin_oe_n,
  // system interrupt
  output logic o_irq
);

  initial begin
    if (PINS != PIN_COUNT) begin
      $error("gpio_port: register fields hold exactly six pins");
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register state

  logic [PINS-1:0] pin_direction_bits;
  logic [PINS-1:0] pin_data_bits;
  logic [PINS-1:0] pin_irq_polarity_bits;
  logic [PINS-1:0] pin_buffer_type_bits;
  logic [PINS-1:0] pin_irq_status;
  logic [PINS-1:0] pin_irq_enable;
  logic global_pin_irq_enable;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] pin_active;
  logic [PINS-1:0] readback;
  logic pin_event;
  logic [DATA_W-1:0] next_rdata;

  function automatic logic hit(input reg_req_t req,
                               input logic [ADDR_W-1:0] ofs);
    hit = req.wr && (req.addr == ofs);
  endfunction

  function automatic logic [DATA_W-1:0] pack_fields(
      input logic [PINS-1:0] high, input logic [PINS-1:0] low);
    pack_fields = WORD_ZERO;
    pack_fields[HIGH_FIELD_LSB +: PINS] = high;
    pack_fields[LOW_FIELD_LSB +: PINS] = low;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin sampling

  pin_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_async(i_pin),
    .o_sync(pin_level)
  );

  // a level lasting one 40 ns clock is caught by the sampler; nothing
  // shorter is guaranteed to be seen
  assign pin_active = ~(pin_level ^ pin_irq_polarity_bits);

  //////////////////////////////////////////////////////////////////////////
  // configuration writes

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_direction_bits <= PIN_FIELD_RST;
      pin_data_bits <= PIN_FIELD_RST;
    end else if (hit(i_req, OFS_DATA_DIR)) begin
      pin_direction_bits <= i_req.wdata[HIGH_FIELD_LSB +: PINS];
      pin_data_bits <= i_req.wdata[LOW_FIELD_LSB +: PINS];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_irq_polarity_bits <= PIN_FIELD_RST;
      pin_buffer_type_bits <= PIN_FIELD_RST;
    end else if (hit(i_req, OFS_PIN_CONFIG)) begin
      pin_irq_polarity_bits <= i_req.wdata[HIGH_FIELD_LSB +: PINS];
      pin_buffer_type_bits <= i_req.wdata[LOW_FIELD_LSB +: PINS];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_irq_enable <= PIN_FIELD_RST;
    end else if (hit(i_req, OFS_GLOBAL_INTERRUPT_STATUS_EN)) begin
      pin_irq_enable <= i_req.wdata[HIGH_FIELD_LSB +: PINS];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      global_pin_irq_enable <= 1'b0;
    end else if (hit(i_req, OFS_GLOBAL_ENABLE)) begin
      global_pin_irq_enable <= i_req.wdata[PIN_EVENT_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt status

  // a still-active level sets the bit again in the clearing cycle, so a
  // level source cannot be acknowledged away while it persists
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_irq_status <= PIN_FIELD_RST;
    end else if (hit(i_req, OFS_GLOBAL_INTERRUPT_STATUS_EN)) begin
      pin_irq_status <= (pin_irq_status
        & ~i_req.wdata[LOW_FIELD_LSB +: PINS]) | pin_active;
    end else begin
      pin_irq_status <= pin_irq_status | pin_active;
    end
  end

  assign pin_event = |(pin_irq_status & pin_irq_enable);
  assign o_irq = pin_event & global_pin_irq_enable;

  //////////////////////////////////////////////////////////////////////////
  // pin drivers

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_out <= PIN_FIELD_RST;
      o_pin_oe_n <= ~PIN_FIELD_RST;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (!pin_direction_bits[i]) begin
          o_pin_out[i] <= 1'b0;
          o_pin_oe_n[i] <= 1'b1;
        end else if (pin_buffer_type_bits[i]) begin
          o_pin_out[i] <= pin_data_bits[i];
          o_pin_oe_n[i] <= 1'b0;
        end else begin
          o_pin_out[i] <= 1'b0;
          o_pin_oe_n[i] <= pin_data_bits[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register reads

  assign readback = (pin_direction_bits & pin_data_bits)
    | (~pin_direction_bits & pin_level);

  always_comb begin
    next_rdata = WORD_ZERO;
    unique case (i_req.addr)
      OFS_DATA_DIR: begin
        next_rdata = pack_fields(pin_direction_bits, readback);
      end
      OFS_PIN_CONFIG: begin
        next_rdata = pack_fields(pin_irq_polarity_bits, pin_buffer_type_bits);
      end
      OFS_GLOBAL_INTERRUPT_STATUS_EN: begin
        next_rdata = pack_fields(pin_irq_enable, pin_irq_status);
      end
      OFS_GLOBAL_STATUS: begin
        next_rdata[PIN_EVENT_BIT] = pin_event;
      end
      OFS_GLOBAL_ENABLE: begin
        next_rdata[PIN_EVENT_BIT] = global_pin_irq_enable;
      end
      default: begin
        next_rdata = WORD_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rsp.rdata <= WORD_ZERO;
    end else if (i_req.rd) begin
      o_rsp.rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rsp.ack <= 1'b0;
    end else begin
      o_rsp.ack <= i_req.rd | i_req.wr;
    end
  end

endmodule // gpio_port

// >>> tb/gpio_port_checker.sv
// Purpose: port-level checks for gpio_port
// Assumes: one clock, ports only
// Notes: pin outputs move two edges after a write
module gpio_port_checker
  import gpio_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire reg_req_t i_req,
  input wire reg_rsp_t o_rsp,
  input wire logic [PINS-1:0] i_pin,
  input wire logic [PINS-1:0] o_pin_out,
  input wire logic [PINS-1:0] o_pin_oe_n,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic dd_wr;
  logic gs_rd;
  assign dd_wr = i_req.wr && i_req.addr == OFS_DATA_DIR;
  assign gs_rd = i_req.rd && i_req.addr == OFS_GLOBAL_STATUS;
  a_ack_follows_req: assert property ((i_req.rd || i_req.wr) |=> o_rsp.ack)
    else $error("ack missing");
  a_no_stray_ack: assert property (!(i_req.rd || i_req.wr) |=> !o_rsp.ack)
    else $error("stray ack");
  a_rdata_holds: assert property (!i_req.rd |=> $stable(o_rsp.rdata))
    else $error("rdata moved");
  a_reserved_zero: assert property (i_req.rd && i_req.addr >= OFS_PIN_CONFIG
    |=> (o_rsp.rdata & 32'hFFC0_FFC0) == 32'h0) else $error("reserved set");
  a_unmapped_zero: assert property (i_req.rd && i_req.addr == 12'h100
    |=> o_rsp.rdata == 32'h0) else $error("unmapped data");
  a_event_bit_only: assert property (gs_rd
    |=> (o_rsp.rdata & 32'hFFFF_EFFF) == 32'h0) else $error("status bits");
  a_irq_has_event: assert property (gs_rd && o_irq |=> o_rsp.rdata[12])
    else $error("irq without event");
  a_input_released: assert property (dd_wr
    |-> ##2 &(o_pin_oe_n | $past(i_req.wdata[21:16], 2))) else $error("oe");
  a_drive_matches: assert property (dd_wr |-> ##2
    ((o_pin_out ^ $past(i_req.wdata[5:0], 2)) & ~o_pin_oe_n) == 6'h00)
    else $error("pin value");
  a_reset_inputs: assert property ($rose(i_nrst) |-> &o_pin_oe_n)
    else $error("pins driven after reset");
endmodule // gpio_port_checker
bind gpio_port gpio_port_checker #(.PINS(PINS)) u_chk (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_req(i_req), .o_rsp(o_rsp),
  .i_pin(i_pin), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
  .o_irq(o_irq));

// >>> tb/pin_board.sv
// Purpose: board side of the six pins
// Assumes: every pin has a pull-up
// Notes: the port's drive wins over the board's
module pin_board (
  input wire logic [5:0] i_out,
  input wire logic [5:0] i_oe_n,
  input wire logic [5:0] i_ext,
  input wire logic [5:0] i_ext_en,
  output logic [5:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // released and undriven pins float up, so open drain reads high
  assign o_level = (~i_oe_n & i_out) |
    (i_oe_n & (~i_ext_en | i_ext));
endmodule // pin_board

// >>> tb/gpio_port_tb.sv
// Purpose: randomised bench for gpio_port
// Assumes: pins settle within four cycles
// Notes: the board drives only pins the port leaves as inputs
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t: got %h want %h", $time, a, e); end end
module gpio_port_tb;
  import gpio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  reg_req_t req = '0;
  reg_rsp_t rsp;
  logic [5:0] pin, pout, poe_n, ext = 6'h3f, ext_en = 6'h3f;
  logic [5:0] pol, bt, dir, d, en, st;
  logic irq, ge;
  logic [31:0] rnd = 32'hd2ef, q;
  logic [11:0] ra[5] = '{OFS_PIN_CONFIG, OFS_DATA_DIR, OFS_GLOBAL_INTERRUPT_STATUS_EN,
    OFS_GLOBAL_STATUS, OFS_GLOBAL_ENABLE};
  int failures = 0, num_checks = 0, cyc = 0;
  always #20 i_sys_clk = ~i_sys_clk;
  gpio_port dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_req(req),
    .o_rsp(rsp), .i_pin(pin), .o_pin_out(pout), .o_pin_oe_n(poe_n),
    .o_irq(irq));
  pin_board board (.i_out(pout), .i_oe_n(poe_n), .i_ext(ext),
    .i_ext_en(ext_en), .o_level(pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] oe_exp(input logic [5:0] b, r, v);
    return ~(r & (b | ~v));
  endfunction
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one-cycle request pulse; the registered answer stands for the cycle
  // after the taking edge, so it is read at the following falling edge
  task automatic acc(input logic [11:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] rd);
    @(negedge i_sys_clk);
    req = '{addr: a, wr: w, rd: !w, wdata: wd};
    @(negedge i_sys_clk);
    `CHK(rsp.ack, 1'b1)
    rd = rsp.rdata;
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_nrst = 1'b1;
    foreach (ra[i]) begin
      acc(ra[i], 1'b0, 32'h0, q);
      `CHK(q, (i == 1) ? 32'h0000_003f : 32'h0)
    end
    acc(12'h100, 1'b0, 32'h0, q);
    `CHK(q, 32'h0)
    repeat (40) begin
      repeat (24) rnd = lfsr(rnd);
      bt = rnd[5:0];
      acc(OFS_PIN_CONFIG, 1'b1, rnd | 32'hFFC0_FFC0, q);
      repeat (24) rnd = lfsr(rnd);
      @(negedge i_sys_clk);
      {dir, d, ext, ext_en} = {rnd[21:16], rnd[5:0], rnd[29:24], ~rnd[21:16]};
      acc(OFS_DATA_DIR, 1'b1, rnd | 32'hFFC0_FFC0, q);
      repeat (4) @(posedge i_sys_clk);
      #1 `CHK(poe_n, oe_exp(bt, dir, d))
      `CHK(pout & ~poe_n, d & ~poe_n)
      acc(OFS_DATA_DIR, 1'b0, 32'h0, q);
      `CHK(q, {10'h0, dir, 10'h0, (dir & d) | (~dir & ext)})
    end
    repeat (20) begin
      repeat (24) rnd = lfsr(rnd);
      {pol, en, ge} = {rnd[5:0], rnd[13:8], rnd[16]};
      @(negedge i_sys_clk);
      {ext, ext_en} = {~rnd[5:0], 6'h3f};
      acc(OFS_DATA_DIR, 1'b1, 32'h0, q);
      acc(OFS_PIN_CONFIG, 1'b1, {10'h0, pol, 16'h003f}, q);
      acc(OFS_GLOBAL_ENABLE, 1'b1, {19'h0, ge, 12'h0}, q);
      repeat (4) @(posedge i_sys_clk);
      acc(OFS_GLOBAL_INTERRUPT_STATUS_EN, 1'b1, {10'h0, en, 10'h0, 6'h3f}, q);
      acc(OFS_GLOBAL_INTERRUPT_STATUS_EN, 1'b0, 32'h0, q);
      `CHK(q, {10'h0, en, 16'h0})
      @(negedge i_sys_clk) ext = rnd[29:24];
      repeat (4) @(posedge i_sys_clk);
      st = ~(ext ^ pol);
      // a clear while the level is still active must not stick
      acc(OFS_GLOBAL_INTERRUPT_STATUS_EN, 1'b1, {10'h0, en, 10'h0, 6'h3f}, q);
      acc(OFS_GLOBAL_INTERRUPT_STATUS_EN, 1'b0, 32'h0, q);
      `CHK(q, {10'h0, en, 10'h0, st})
      acc(OFS_GLOBAL_STATUS, 1'b0, 32'h0, q);
      `CHK(q[12], |(st & en))
      `CHK(irq, ge & |(st & en))
    end
    report_and_stop();
  end
endmodule // gpio_port_tb
